// [design/ext_irq_pkg.sv]
// constants, register map and types for the external pin interrupt unit
`default_nettype none
package ext_irq_pkg;

    // register byte offsets on the register bus
    localparam logic [7:0] SENSE_CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] MASK_REGISTER_OFFSET = 8'h04;
    localparam logic [7:0] FLAG_REGISTER_OFFSET = 8'h08;
    localparam logic [7:0] UPPER_MASK_OFFSET = 8'h0c;
    localparam logic [7:0] LOWER_MASK_OFFSET = 8'h10;
    localparam logic [7:0] PIN_STATUS_OFFSET = 8'h14;

    // field positions
    localparam int SENSE_SELECT_LOW_BIT = 0;
    localparam int SENSE_SELECT_HIGH_BIT = 1;
    localparam int UPPER_GROUP_BIT = 7;
    localparam int LOWER_GROUP_BIT = 6;
    localparam int DEDICATED_BIT = 0;
    localparam int PIN_STATUS_DEDICATED_BIT = 16;

    // values after reset
    localparam logic [7:0] MASK_REGISTER_RESET = 8'h00;
    localparam logic [7:0] GROUP_MASK_RESET = 8'h00;
    localparam logic [7:0] FLAG_REGISTER_RESET = 8'h00;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL = 2'b00,
        SENSE_ANY_CHANGE = 2'b01,
        SENSE_FALLING = 2'b10,
        SENSE_RISING = 2'b11
    } sense_mode_type;

    // software configuration carried as one bundle
    typedef struct packed {
        sense_mode_type sense;
        logic upper_group_enable;
        logic lower_group_enable;
        logic dedicated_enable;
        logic [7:0] upper_pin_change_mask;
        logic [7:0] lower_pin_change_mask;
    } config_type;

    // sticky flags
    typedef struct packed {
        logic upper;
        logic lower;
        logic dedicated;
    } flag_set_type;

    localparam config_type CONFIG_RESET = '{
        sense: SENSE_LOW_LEVEL,
        upper_group_enable: 1'b0,
        lower_group_enable: 1'b0,
        dedicated_enable: 1'b0,
        upper_pin_change_mask: GROUP_MASK_RESET,
        lower_pin_change_mask: GROUP_MASK_RESET
    };

endpackage : ext_irq_pkg
`default_nettype wire

// [design/pin_sync.sv]
// two-flop synchroniser for a vector of pin levels
`default_nettype none
`timescale 1ns/100ps
module pin_sync
    import ext_irq_pkg::*;
#(
    parameter int WIDTH = 17
)
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    if (WIDTH < 1)
    begin : g_width_check
        $error("pin_sync: WIDTH must be at least one");
    end

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds only the second stage
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule : pin_sync
`default_nettype wire

// [design/dedicated_edge_sense.sv]
// sense-mode qualified event detection for the dedicated interrupt pin
`default_nettype none
`timescale 1ns/100ps
module dedicated_edge_sense
    import ext_irq_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_pin_sampled,
    input wire sense_mode_type i_mode,
    input wire logic i_io_clk_run,
    output logic o_edge_event,
    output logic o_low_level
);
    logic prev_ff;
    logic nxt_prev;
    logic rise;
    logic fall;

    always_comb
    begin
        nxt_prev = i_pin_sampled;
        rise = i_pin_sampled & ~prev_ff;
        fall = ~i_pin_sampled & prev_ff;
        o_edge_event = 1'b0;
        // edges need the i/o clock; low level does not
        if (i_io_clk_run)
        begin
            case (i_mode)
                SENSE_ANY_CHANGE: o_edge_event = rise | fall;
                SENSE_FALLING: o_edge_event = fall;
                SENSE_RISING: o_edge_event = rise;
                default: o_edge_event = 1'b0;
            endcase
        end
        o_low_level = (i_mode == SENSE_LOW_LEVEL) & ~i_pin_sampled;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            prev_ff <= 1'b1;
        else
            prev_ff <= nxt_prev;
    end

endmodule : dedicated_edge_sense
`default_nettype wire

// [design/external_pin_interrupt_unit.sv]
// external pin interrupt unit with register bus slave
`default_nettype none
`timescale 1ns/100ps
// Overview of operation
// - pins are read at the pad, so output pins still interrupt
// - a toggle on an unmasked upper pin raises the upper request
// - a toggle on an unmasked lower pin raises the lower request
// - each group has its own pin mask
// - pin changes are caught without the i/o clock
// - level mode requests while the dedicated pin stays low
// - dedicated edges are seen only while the i/o clock runs
// - a low dedicated pin is seen without the i/o clock
// - a dropped level ends the wake and the request in the same cycle
// - dedicated request needs global enable and its mask bit
// - dedicated pin is sampled; pulses over one clock interrupt
// - sense control sits in bits 1 and 0
// - sense codes: 00 low, 01 change, 10 falling, 11 rising
// - each source flag clears by service or by writing one
// - dedicated flag reads cleared in level mode
// - mask register: upper bit 7, lower bit 6, dedicated bit 0
// - a pin triggers only with its mask bit and group enable
module external_pin_interrupt_unit
    import ext_irq_pkg::*;
#(
    parameter int GROUP_WIDTH = 8,
    parameter int ADDR_WIDTH = 8
)
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_dedicated_irq_pin,
    input wire logic [2*GROUP_WIDTH-1:0] i_pin_change_inputs,
    input wire logic i_global_irq_enable,
    input wire logic i_io_clk_run,
    input wire logic [2:0] i_irq_ack,
    output logic o_dedicated_irq_req,
    output logic o_upper_pin_change_request,
    output logic o_lower_pin_change_request,
    output logic o_wake_req,
    input wire logic [ADDR_WIDTH-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready
);
    // register fields are eight bits wide, so groups must be exactly eight
    if (GROUP_WIDTH != 8 || ADDR_WIDTH < 8)
    begin : g_param_check
        $error("GROUP_WIDTH must be 8 and ADDR_WIDTH at least 8");
    end
    localparam int PINS = 2 * GROUP_WIDTH;
    function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] a,
                                     input logic [7:0] off);
        addr_is = (a[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(off[7:2]));
    endfunction : addr_is
    function automatic logic known_addr(input logic [ADDR_WIDTH-1:0] a);
        // offsets are contiguous words up to the pin status register
        known_addr = a[ADDR_WIDTH-1:2]
            <= (ADDR_WIDTH-2)'(PIN_STATUS_OFFSET[7:2]);
    endfunction : known_addr
    // pin sampling
    logic [PINS:0] pins_sync;
    logic [PINS-1:0] pc_now;
    logic ded_now;
    // pins read at the pad whatever their direction; dedicated pin kept
    // inverted so a reset synchroniser reads idle high, no false edge
    pin_sync #(
        .WIDTH(PINS + 1)
    ) u_pin_sync (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_async({~i_dedicated_irq_pin, i_pin_change_inputs}),
        .o_sync(pins_sync)
    );
    assign pc_now = pins_sync[PINS-1:0];
    assign ded_now = ~pins_sync[PINS];
    config_type cfg_ff, nxt_cfg;
    flag_set_type flag_ff, nxt_flag;
    logic ded_edge, ded_low;
    dedicated_edge_sense u_edge (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_pin_sampled(ded_now),
        .i_mode(cfg_ff.sense),
        .i_io_clk_run(i_io_clk_run),
        .o_edge_event(ded_edge),
        .o_low_level(ded_low)
    );
    // pin-change toggle detection, independent of the i/o clock
    logic [PINS-1:0] pc_prev_ff, nxt_pc_prev, pc_toggle;
    logic upper_hit, lower_hit;
    always_comb
    begin
        nxt_pc_prev = pc_now;
        pc_toggle = pc_now ^ pc_prev_ff;
        upper_hit = |(pc_toggle[PINS-1:GROUP_WIDTH]
            & cfg_ff.upper_pin_change_mask);
        lower_hit = |(pc_toggle[GROUP_WIDTH-1:0]
            & cfg_ff.lower_pin_change_mask);
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            pc_prev_ff <= '0;
        else
            pc_prev_ff <= nxt_pc_prev;
    end
    // register bus: write side
    logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
    logic nxt_aw_held, nxt_w_held, nxt_awready, nxt_wready, nxt_bvalid;
    logic [ADDR_WIDTH-1:0] waddr_ff, nxt_waddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic [1:0] bresp_ff, nxt_bresp;
    logic do_write, wr_lane0;
    always_comb
    begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held = w_held_ff;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
        wr_lane0 = do_write & wstrb_ff[0];
        if (i_s_axi_awvalid && awready_ff)
        begin
            nxt_aw_held = 1'b1;
            nxt_waddr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && wready_ff)
        begin
            nxt_w_held = 1'b1;
            nxt_wdata = i_s_axi_wdata;
            nxt_wstrb = i_s_axi_wstrb;
        end
        if (bvalid_ff && i_s_axi_bready)
            nxt_bvalid = 1'b0;
        if (do_write)
        begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = known_addr(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end
        // one write in flight; ready drops while a response waits
        nxt_awready = ~nxt_aw_held & ~nxt_bvalid;
        nxt_wready = ~nxt_w_held & ~nxt_bvalid;
    end
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            waddr_ff <= '0;
            wdata_ff <= READ_ZERO;
            wstrb_ff <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
        end
    end
    // configuration registers
    always_comb
    begin
        nxt_cfg = cfg_ff;
        if (wr_lane0 && addr_is(waddr_ff, SENSE_CONTROL_OFFSET))
            nxt_cfg.sense = sense_mode_type'(
                wdata_ff[SENSE_SELECT_HIGH_BIT:SENSE_SELECT_LOW_BIT]);
        if (wr_lane0 && addr_is(waddr_ff, MASK_REGISTER_OFFSET))
        begin
            nxt_cfg.upper_group_enable = wdata_ff[UPPER_GROUP_BIT];
            nxt_cfg.lower_group_enable = wdata_ff[LOWER_GROUP_BIT];
            nxt_cfg.dedicated_enable = wdata_ff[DEDICATED_BIT];
        end
        if (wr_lane0 && addr_is(waddr_ff, UPPER_MASK_OFFSET))
            nxt_cfg.upper_pin_change_mask = wdata_ff[7:0];
        if (wr_lane0 && addr_is(waddr_ff, LOWER_MASK_OFFSET))
            nxt_cfg.lower_pin_change_mask = wdata_ff[7:0];
    end
    // sticky flags: a set in the same cycle as a clear wins
    logic level_mode, flag_w1c;
    always_comb
    begin
        level_mode = (cfg_ff.sense == SENSE_LOW_LEVEL);
        flag_w1c = wr_lane0 && addr_is(waddr_ff, FLAG_REGISTER_OFFSET);
        nxt_flag.upper = upper_hit | (flag_ff.upper & ~i_irq_ack[2]
            & ~(flag_w1c & wdata_ff[UPPER_GROUP_BIT]));
        nxt_flag.lower = lower_hit | (flag_ff.lower & ~i_irq_ack[1]
            & ~(flag_w1c & wdata_ff[LOWER_GROUP_BIT]));
        nxt_flag.dedicated = ~level_mode
            & (ded_edge | (flag_ff.dedicated & ~i_irq_ack[0]
            & ~(flag_w1c & wdata_ff[DEDICATED_BIT])));
    end
    // requests to the processor and wake-up
    logic ded_req_ff, upper_req_ff, lower_req_ff, wake_ff;
    logic nxt_ded_req, nxt_upper_req, nxt_lower_req, nxt_wake;
    always_comb
    begin
        // level mode follows the pin, so a level that vanishes drops it
        nxt_ded_req = i_global_irq_enable & cfg_ff.dedicated_enable
            & (level_mode ? ded_low : nxt_flag.dedicated);
        nxt_upper_req = i_global_irq_enable & cfg_ff.upper_group_enable
            & nxt_flag.upper;
        nxt_lower_req = i_global_irq_enable & cfg_ff.lower_group_enable
            & nxt_flag.lower;
        // wake sources do not depend on the i/o clock running
        nxt_wake = (cfg_ff.upper_group_enable & upper_hit)
            | (cfg_ff.lower_group_enable & lower_hit)
            | (cfg_ff.dedicated_enable & ded_low);
    end
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            cfg_ff <= CONFIG_RESET;
            flag_ff <= '0;
            ded_req_ff <= 1'b0;
            upper_req_ff <= 1'b0;
            lower_req_ff <= 1'b0;
            wake_ff <= 1'b0;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
            flag_ff <= nxt_flag;
            ded_req_ff <= nxt_ded_req;
            upper_req_ff <= nxt_upper_req;
            lower_req_ff <= nxt_lower_req;
            wake_ff <= nxt_wake;
        end
    end
    // register bus: read side
    logic arready_ff, rvalid_ff, nxt_arready, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata, rd_word;
    logic [1:0] rresp_ff, nxt_rresp;
    always_comb
    begin
        rd_word = READ_ZERO;
        if (addr_is(i_s_axi_araddr, SENSE_CONTROL_OFFSET))
            rd_word[SENSE_SELECT_HIGH_BIT:SENSE_SELECT_LOW_BIT] = cfg_ff.sense;
        if (addr_is(i_s_axi_araddr, MASK_REGISTER_OFFSET))
        begin
            rd_word[UPPER_GROUP_BIT] = cfg_ff.upper_group_enable;
            rd_word[LOWER_GROUP_BIT] = cfg_ff.lower_group_enable;
            rd_word[DEDICATED_BIT] = cfg_ff.dedicated_enable;
        end
        if (addr_is(i_s_axi_araddr, FLAG_REGISTER_OFFSET))
        begin
            rd_word[UPPER_GROUP_BIT] = flag_ff.upper;
            rd_word[LOWER_GROUP_BIT] = flag_ff.lower;
            rd_word[DEDICATED_BIT] = flag_ff.dedicated & ~level_mode;
        end
        if (addr_is(i_s_axi_araddr, UPPER_MASK_OFFSET))
            rd_word[7:0] = cfg_ff.upper_pin_change_mask;
        if (addr_is(i_s_axi_araddr, LOWER_MASK_OFFSET))
            rd_word[7:0] = cfg_ff.lower_pin_change_mask;
        if (addr_is(i_s_axi_araddr, PIN_STATUS_OFFSET))
        begin
            rd_word[PINS-1:0] = pc_now;
            rd_word[PIN_STATUS_DEDICATED_BIT] = ded_now;
        end
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && i_s_axi_rready)
            nxt_rvalid = 1'b0;
        if (i_s_axi_arvalid && arready_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_word;
            nxt_rresp = known_addr(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        nxt_arready = ~nxt_rvalid;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= READ_ZERO;
            rresp_ff <= RESP_OKAY;
        end
        else
        begin
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign o_dedicated_irq_req = ded_req_ff;
    assign o_upper_pin_change_request = upper_req_ff;
    assign o_lower_pin_change_request = lower_req_ff;
    assign o_wake_req = wake_ff;
    assign o_s_axi_awready = awready_ff;
    assign o_s_axi_wready = wready_ff;
    assign o_s_axi_bvalid = bvalid_ff;
    assign o_s_axi_bresp = bresp_ff;
    assign o_s_axi_arready = arready_ff;
    assign o_s_axi_rvalid = rvalid_ff;
    assign o_s_axi_rdata = rdata_ff;
    assign o_s_axi_rresp = rresp_ff;

endmodule : external_pin_interrupt_unit
`default_nettype wire

// [tb/ext_irq_monitor.sv]
// timing checks on the ports of the pin interrupt unit
`timescale 1ns/100ps
`default_nettype none
module ext_irq_monitor
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_global_irq_enable,
    input wire logic [2:0] i_irq_ack,
    input wire logic o_dedicated_irq_req,
    input wire logic o_upper_pin_change_request,
    input wire logic o_lower_pin_change_request,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic o_s_axi_bvalid,
    input wire logic [1:0] o_s_axi_bresp,
    input wire logic i_s_axi_bready,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic o_s_axi_rvalid,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic i_s_axi_rready
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);

    a_ded_global_gate: assert property (o_dedicated_irq_req
        |-> $past(i_global_irq_enable))
        else $error("dedicated request without global enable");
    a_upper_global_gate: assert property ($rose(
        o_upper_pin_change_request) |-> $past(i_global_irq_enable))
        else $error("upper request without global enable");
    a_lower_global_gate: assert property (!i_global_irq_enable
        |=> !o_lower_pin_change_request)
        else $error("lower request without global enable");
    // ack and bus writes may clear the flag, so both are excluded
    a_upper_req_holds: assert property (o_upper_pin_change_request
        && i_global_irq_enable && !i_irq_ack[2] && !$past(i_irq_ack[2])
        && o_s_axi_awready && !i_s_axi_wvalid
        |=> o_upper_pin_change_request)
        else $error("upper request dropped without a clear");
    a_b_latency: assert property (i_s_axi_awvalid && o_s_axi_awready
        && i_s_axi_wvalid && o_s_axi_wready |-> ##2 o_s_axi_bvalid)
        else $error("write response late");
    a_b_stands: assert property (o_s_axi_bvalid && !i_s_axi_bready
        |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response not held");
    a_r_latency: assert property (i_s_axi_arvalid && o_s_axi_arready
        |=> o_s_axi_rvalid && !o_s_axi_arready)
        else $error("read data late");
    a_r_stands: assert property (o_s_axi_rvalid && !i_s_axi_rready
        |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data not held");
endmodule : ext_irq_monitor

bind external_pin_interrupt_unit ext_irq_monitor mon (.*);
`default_nettype wire

// [tb/irq_host_model.sv]
// processor side model that services raised requests
`timescale 1ns/100ps
`default_nettype none
module irq_host_model
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [2:0] i_req,
    input wire logic i_serve,
    input wire logic i_slow,
    output logic [2:0] o_ack
);
    logic [3:0] cnt_ff, nxt_cnt;
    logic [2:0] pend_ff, nxt_pend, nxt_ack;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_pend = pend_ff;
        nxt_ack = 3'h0;
        if (cnt_ff != 4'h0)
        begin
            nxt_cnt = cnt_ff - 4'h1;
            // only still-raised sources are served, one pulse each
            if (cnt_ff == 4'h1)
            begin
                nxt_ack = pend_ff & i_req;
            end
        end
        else if (i_serve && (|i_req))
        begin
            nxt_cnt = i_slow ? 4'h9 : 4'h1;
            nxt_pend = i_req;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            cnt_ff <= 4'h0;
            pend_ff <= 3'h0;
            o_ack <= 3'h0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            pend_ff <= nxt_pend;
            o_ack <= nxt_ack;
        end
    end
endmodule : irq_host_model
`default_nettype wire

// [tb/external_pin_interrupt_unit_tb_top.sv]
// self-checking bench for the external pin interrupt unit
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupt_unit_tb_top;
    import ext_irq_pkg::*;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_dedicated_irq_pin = 1'b1;
    logic [15:0] i_pin_change_inputs = 16'h0000;
    logic i_global_irq_enable = 1'b0, i_io_clk_run = 1'b1;
    logic [2:0] i_irq_ack;
    logic o_dedicated_irq_req, o_upper_pin_change_request;
    logic o_lower_pin_change_request, o_wake_req, serve = 1'b0;
    logic slow = 1'b0, i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0;
    logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00, m;
    logic [31:0] i_s_axi_wdata = 32'h0000_0000, o_s_axi_rdata;
    logic [3:0] i_s_axi_wstrb = 4'hf;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
    logic o_s_axi_arready, o_s_axi_rvalid, i_s_axi_bready = 1'b0;
    logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, bq[$];
    logic [33:0] rq[$];
    logic [15:0] rnd = 16'h364a;
    logic [2:0] p, q;
    logic [7:0] offs[5] = '{SENSE_CONTROL_OFFSET, MASK_REGISTER_OFFSET,
        FLAG_REGISTER_OFFSET, UPPER_MASK_OFFSET, LOWER_MASK_OFFSET};
    int miscompares = 0, num_checks = 0;

    external_pin_interrupt_unit dut (.*);
    irq_host_model host (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_req({o_upper_pin_change_request, o_lower_pin_change_request,
        o_dedicated_irq_req}), .i_serve(serve), .i_slow(slow),
        .o_ack(i_irq_ack));

    initial
    begin
        forever #5 i_mclk = ~i_mclk;
    end

    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function logic req_of(input int g);
        return g ? o_upper_pin_change_request : o_lower_pin_change_request;
    endfunction : req_of

    task test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    task stop_run;
        miscompares++;
        test_done;
    endtask : stop_run

    task chk(input logic [33:0] s, input logic [33:0] e, input string n);
        num_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("wrong value %s exp %h saw %h", n, e, s);
        end
    endtask : chk

    task step(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : step

    // the response ready is raised one cycle late to exercise stalls
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        bq.push_back(r);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            n++;
            if (o_s_axi_awready === 1'b1) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready === 1'b1) i_s_axi_wvalid <= 1'b0;
            if (o_s_axi_bvalid === 1'b1) i_s_axi_bready <= 1'b1;
        end
        while (!(o_s_axi_bvalid === 1'b1 && i_s_axi_bready) && n < 40);
        i_s_axi_bready <= 1'b0;
        if (n >= 40) stop_run;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        rq.push_back({r, e});
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            n++;
            if (o_s_axi_arready === 1'b1) i_s_axi_arvalid <= 1'b0;
            if (o_s_axi_rvalid === 1'b1) i_s_axi_rready <= 1'b1;
        end
        while (!(o_s_axi_rvalid === 1'b1 && i_s_axi_rready) && n < 40);
        i_s_axi_rready <= 1'b0;
        if (n >= 40) stop_run;
    endtask : rd

    always @(posedge i_mclk)
    begin
        if (o_s_axi_bvalid === 1'b1 && i_s_axi_bready)
            chk(o_s_axi_bresp, bq.pop_front(), "bresp");
        if (o_s_axi_rvalid === 1'b1 && i_s_axi_rready)
            chk({o_s_axi_rresp, o_s_axi_rdata}, rq.pop_front(), "read");
    end

    initial
    begin
        step(3);
        i_sys_rst <= 1'b0;
        step(3);
        foreach (offs[k]) rd(offs[k], 32'h0000_0000, RESP_OKAY);
        rd(PIN_STATUS_OFFSET, 32'h0001_0000, RESP_OKAY);
        rd(8'h18, READ_ZERO, RESP_SLVERR);
        wr(8'h18, 32'h0000_00ff, RESP_SLVERR);
        i_s_axi_wstrb <= 4'h0;
        wr(LOWER_MASK_OFFSET, 32'h0000_00ff, RESP_OKAY);
        i_s_axi_wstrb <= 4'hf;
        rd(LOWER_MASK_OFFSET, 32'h0000_0000, RESP_OKAY);
        $display("test registers done");
        i_global_irq_enable <= 1'b1;
        i_io_clk_run <= 1'b0;
        for (int g = 0; g < 2; g++)
        begin
            rnd = lfsr(rnd);
            p = rnd[10:8];
            q = p + 3'h1;
            m = (rnd[7:0] | (8'h01 << p)) & ~(8'h01 << q);
            wr(g ? UPPER_MASK_OFFSET : LOWER_MASK_OFFSET, {24'h0, m}, 2'h0);
            wr(MASK_REGISTER_OFFSET, 32'h1 << (6 + g), RESP_OKAY);
            i_pin_change_inputs[g * 8 + q] <= ~i_pin_change_inputs[g * 8 + q];
            step(6);
            chk(req_of(g), 1'b0, "masked pin");
            rd(FLAG_REGISTER_OFFSET, 32'h0000_0000, RESP_OKAY);
            i_pin_change_inputs[g * 8 + p] <= ~i_pin_change_inputs[g * 8 + p];
            step(6);
            chk(req_of(g), 1'b1, "pin change");
            i_global_irq_enable <= 1'b0;
            step(3);
            chk(req_of(g), 1'b0, "global gate");
            i_global_irq_enable <= 1'b1;
            wr(FLAG_REGISTER_OFFSET, 32'h1 << (6 + g), RESP_OKAY);
            step(3);
            chk(req_of(g), 1'b0, "write clear");
            i_pin_change_inputs[g * 8 + p] <= ~i_pin_change_inputs[g * 8 + p];
            serve <= 1'b1;
            slow <= 1'(g);
            step(6);
            if (g == 1) chk(req_of(g), 1'b1, "before service");
            step(14);
            chk(req_of(g), 1'b0, "serviced");
            serve <= 1'b0;
        end
        $display("test pin change done");
        i_io_clk_run <= 1'b1;
        wr(MASK_REGISTER_OFFSET, 32'h0000_0001, RESP_OKAY);
        for (int md = 1; md < 4; md++)
        begin
            wr(SENSE_CONTROL_OFFSET, 32'hffff_fffc | md, RESP_OKAY);
            rd(SENSE_CONTROL_OFFSET, md, RESP_OKAY);
            wr(FLAG_REGISTER_OFFSET, 32'h0000_0001, RESP_OKAY);
            i_dedicated_irq_pin <= 1'b0;
            step(6);
            chk(o_dedicated_irq_req, md != 3, "fall");
            wr(FLAG_REGISTER_OFFSET, 32'h0000_0001, RESP_OKAY);
            i_dedicated_irq_pin <= 1'b1;
            step(6);
            chk(o_dedicated_irq_req, md != 2, "rise");
            wr(FLAG_REGISTER_OFFSET, 32'h0000_0001, RESP_OKAY);
        end
        wr(SENSE_CONTROL_OFFSET, {30'h0, SENSE_FALLING}, RESP_OKAY);
        i_io_clk_run <= 1'b0;
        i_dedicated_irq_pin <= 1'b0;
        step(6);
        chk(o_dedicated_irq_req, 1'b0, "clock stopped");
        i_dedicated_irq_pin <= 1'b1;
        step(6);
        i_io_clk_run <= 1'b1;
        $display("test edge modes done");
        wr(SENSE_CONTROL_OFFSET, {30'h0, SENSE_LOW_LEVEL}, RESP_OKAY);
        i_io_clk_run <= 1'b0;
        i_dedicated_irq_pin <= 1'b0; // held low through the wake, request and gate checks
        step(6);
        chk(o_wake_req, 1'b1, "level wake");
        i_io_clk_run <= 1'b1;
        step(3);
        chk(o_dedicated_irq_req, 1'b1, "level request");
        i_global_irq_enable <= 1'b0;
        step(3);
        chk(o_dedicated_irq_req, 1'b0, "level gate");
        i_global_irq_enable <= 1'b1;
        rd(FLAG_REGISTER_OFFSET, 32'h0000_0000, RESP_OKAY);
        i_dedicated_irq_pin <= 1'b1;
        step(6);
        chk(o_dedicated_irq_req, 1'b0, "level released");
        i_sys_rst <= 1'b1;
        step(2);
        i_sys_rst <= 1'b0;
        step(3);
        rd(MASK_REGISTER_OFFSET, 32'h0000_0000, RESP_OKAY);
        $display("test level mode done");
        test_done;
    end
endmodule : external_pin_interrupt_unit_tb_top
`default_nettype wire
